// ### dv/can_node_model.sv
`timescale 1ns/1ns
// remote node behind a transceiver: the bus is wired-and, either side pulls
// it dominant and the pull-up makes it recessive when nobody drives
module can_node_model
(
	input wire logic node_tx,
	input wire logic drive,
	output logic bus_lvl
);
	// dominant wins, so a remote edge shows even while the device sends recessive
	assign bus_lvl = node_tx & drive;
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ns
`include "can_bit_timing_defines.svh"
module testbench;
	import can_bit_timing_pkg::*;
	logic clk = 1'b0; // system clock
	logic rstn = 1'b0; // reset, active low
	axil_req_t req = '0; // register bus requests
	axil_rsp_t rsp; // register bus answers
	logic can_tx, rx_bit, sample_point, bus_lvl;
	logic tx_bit = 1'b1; // next bit to send, recessive
	logic bus_idle = 1'b0; // protocol idle flag
	logic drv = 1'b1; // remote node drive, recessive
	int err_total = 0;
	int checked = 0;
	int t;
	int k;
	logic [31:0] d;
	logic [1:0] r;
	// timing words and extensions: two typical rates plus the extreme lengths
	logic [15:0] bv [6] = '{16'h34F1, 16'h2301, 16'h0204, 16'h0100, 16'h7F00, 16'h013F};
	logic [3:0] ev [6] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'hF};

	// clock: 4 ns period
	always #2 clk = ~clk;

	can_bit_timing can_bit_timing_i (.clk(clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp), .can_rx(bus_lvl),
		.can_tx(can_tx), .tx_bit(tx_bit), .bus_idle(bus_idle), .rx_bit(rx_bit), .sample_point(sample_point));
	can_node_model can_node_model_i (.node_tx(can_tx), .drive(drv), .bus_lvl(bus_lvl));

	// print the counts and the verdict, then end the run
	task automatic stop_test;
		$display("mismatches %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// a wait that ran out counts as a mismatch
	task automatic hang;
		err_total++;
		stop_test();
	endtask

	// compare and report at once
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask

	// write: address and data offered together, each dropped at the edge it is taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] dw, output logic [1:0] rs);
		int n;
		logic b;
		b = 1'b0;
		rs = 2'h3;
		@(posedge clk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= dw;
		req.wstrb <= 4'hF;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 64 && !b; n++)
		begin
			@(posedge clk);
			b = rsp.bvalid;
			if (b)
				rs = rsp.bresp;
			req.awvalid <= req.awvalid & ~rsp.awready;
			req.wvalid <= req.wvalid & ~rsp.wready;
			req.bready <= ~b;
		end
		if (!b)
			hang();
	endtask

	// read: rready held until rvalid is seen
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] dr, output logic [1:0] rs);
		int n;
		logic b;
		b = 1'b0;
		rs = 2'h3;
		dr = 32'h0;
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 64 && !b; n++)
		begin
			@(posedge clk);
			b = rsp.rvalid;
			if (b)
			begin
				dr = rsp.rdata;
				rs = rsp.rresp;
			end
			req.arvalid <= req.arvalid & ~rsp.arready;
			req.rready <= ~b;
		end
		if (!b)
			hang();
	endtask

	// clocks up to and including the next sample point pulse
	task automatic wait_sp(output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (sample_point !== 1'b1 && n < 5000);
		if (n >= 5000)
			hang();
	endtask

	// program timing under init, release init, align to a sample point
	task automatic cfg(input logic [15:0] b, input logic [3:0] e);
		axi_wr(`OFF_CTL, 32'h0000_0041, r);
		axi_wr(`OFF_BIT, {16'h0000, b}, r);
		axi_wr(`OFF_EXT, {28'h0000000, e}, r);
		axi_wr(`OFF_CTL, 32'h0000_0000, r);
		wait_sp(t);
	endtask

	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("tx in init", 32'h1, {31'h0, can_tx});
		axi_rd(`OFF_CTL, d, r);
		chk("ctl reset", 32'h1, d);
		axi_rd(`OFF_BIT, d, r);
		chk("bit reset", 32'h2301, d);
		axi_rd(`OFF_EXT, d, r);
		chk("ext reset", 32'h0, d);
		// status: sync segment, recessive pin and level, nothing sampled yet
		axi_rd(`OFF_STAT, d, r);
		chk("status reset", 32'h6, d);
		axi_wr(`OFF_STAT, 32'hFFFF_FFFF, r);
		chk("status wr resp", 32'h0, {30'h0, r});
		axi_rd(`OFF_STAT, d, r);
		chk("status after wr", 32'h6, d);
		axi_rd(12'h004, d, r);
		chk("unmapped rd resp", 32'h2, {30'h0, r});
		chk("unmapped rd data", 32'h0, d);
		axi_wr(12'h008, 32'h0000_FFFF, r);
		chk("unmapped wr resp", 32'h2, {30'h0, r});
		// timing writes refused unless init and change enable are both set
		axi_wr(`OFF_BIT, 32'h0000_0204, r);
		axi_rd(`OFF_BIT, d, r);
		chk("bit without cce", 32'h2301, d);
		axi_wr(`OFF_CTL, 32'h0000_0040, r);
		axi_wr(`OFF_BIT, 32'h0000_0204, r);
		axi_rd(`OFF_BIT, d, r);
		chk("bit without init", 32'h2301, d);
		axi_wr(`OFF_EXT, 32'h0000_0005, r);
		axi_rd(`OFF_EXT, d, r);
		chk("ext without init", 32'h0, d);
		axi_wr(`OFF_CTL, 32'h0000_0041, r);
		axi_wr(`OFF_BIT, 32'h0000_34F1, r);
		axi_rd(`OFF_BIT, d, r);
		chk("bit open", 32'h34F1, d);
		// bit length in clocks = (seg1 + seg2 + 3) quanta of ({ext,brp} + 1) clocks
		for (k = 0; k < 6; k++)
		begin
			cfg(bv[k], ev[k]);
			wait_sp(t);
			chk("bit clocks", (bv[k][11:8] + bv[k][14:12] + 3) * ({ev[k], bv[k][5:0]} + 1), t);
		end
		// 4 clk quanta, seg1 4, seg2 3, jump 2: 32 clocks a bit
		cfg(16'h2343, 4'h0);
		tx_bit <= 1'b0;
		repeat (3) wait_sp(t);
		chk("tx dominant", 32'h0, {31'h0, can_tx});
		chk("rx dominant", 32'h0, {31'h0, rx_bit});
		tx_bit <= 1'b1;
		repeat (3) wait_sp(t);
		chk("rx recessive", 32'h1, {31'h0, rx_bit});
		// remote edge early in phase two: bit ends short, by at most the jump width
		repeat (2) @(posedge clk);
		drv <= 1'b0;
		wait_sp(t);
		chk("short bit", 32'h1, 32'(t >= 22 && t < 30));
		wait_sp(t);
		chk("steady bit", 32'h20, t);
		drv <= 1'b1;
		repeat (2) wait_sp(t);
		// remote edge in the first segment: bit lengthened, by at most the jump width
		repeat (18) @(posedge clk);
		drv <= 1'b0;
		wait_sp(t);
		chk("long bit", 32'h1, 32'(t > 14 && t <= 22));
		drv <= 1'b1;
		bus_idle <= 1'b1;
		repeat (2) wait_sp(t);
		// idle edge late in seg1 restarts the bit, beyond what a resync could shift
		repeat (26) @(posedge clk);
		drv <= 1'b0;
		wait_sp(t);
		chk("hard sync", 32'h1, 32'(t > 16 && t <= 27));
		// reset in mid-run: registers and the transmit pin return to their idle values
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("tx after reset", 32'h1, {31'h0, can_tx});
		axi_rd(`OFF_CTL, d, r);
		chk("ctl after reset", 32'h1, d);
		axi_rd(`OFF_BIT, d, r);
		chk("bit after reset", 32'h2301, d);
		stop_test();
	end
endmodule

// ### include/can_bit_timing_defines.svh
`ifndef CAN_BIT_TIMING_DEFINES_SVH
`define CAN_BIT_TIMING_DEFINES_SVH
// register byte offsets on the axi4-lite port
`define OFF_CTL 12'h000
`define OFF_BIT 12'h00C
`define OFF_EXT 12'h018
`define OFF_STAT 12'h01C
// control register bit positions
`define CTL_INIT 0
`define CTL_CCE 6
// field ranges in the written data word
`define F_BIT 14:0
`define F_EXT 3:0
`define F_STAT 5:0
// reset values
`define INIT_RST 1'h1
`define CCE_RST 1'h0
`define BIT_RST 15'h2301
`define EXT_RST 4'h0
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// bus levels and fixed lengths
`define RECESSIVE 1'h1
`define RX_IDLE 3'h7
`define ONE_TQ 5'h01
`define ONE_CLK 11'h001
`endif

// ### include/can_bit_timing_pkg.sv
package can_bit_timing_pkg;
	// bit timing register, minus-one fields, msb first
	typedef struct packed {
		logic [2:0] second_segment_field;
		logic [3:0] first_segment_field;
		logic [1:0] jump_width;
		logic [5:0] quantum_prescaler;
	} bit_cfg_t;
	// segment currently being counted
	typedef enum logic [1:0] {seg_sync, seg_first_segment_field, seg_second_segment_field} seg_t;
	// axi4-lite master to slave
	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} axil_req_t;
	// axi4-lite slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} axil_rsp_t;
	// prescaler state
	typedef struct packed {
		logic [10:0] cnt;
		logic tick;
	} presc_state_t;
	// pin synchroniser state
	typedef struct packed {
		logic [2:0] ff;
		logic lvl;
	} sync_state_t;
	// main block state
	typedef struct packed {
		logic ctl_init;
		logic ctl_cce;
		bit_cfg_t cfg;
		logic [3:0] ext;
		logic aw_got;
		logic [11:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		axil_rsp_t rsp;
		seg_t seg;
		logic [4:0] cnt;
		logic [4:0] lim1;
		logic [4:0] lim2;
		logic resynced;
		logic last_rx;
		logic rx_bit;
		logic sample;
		logic tx;
	} bt_state_t;
endpackage

// ### rtl/can_bit_timing.sv
`timescale 1ns/1ns
`include "can_bit_timing_defines.svh"
// Functional notes
// - quantum is prescaler count of system clocks
// - bit has sync, prop, phase one, phase two
// - sync segment is always one quantum
// - propagation segment spans one to eight quanta
// - phase one lengthened by resync, one-eight quanta
// - phase two shortened by resync, one-eight quanta
// - jump width 1..4, not above phase segments
// - prescaler 1..64, extension widens to 1024
// - timing fields hold value minus one
// - bit length is fields plus three quanta
// - timing decisions advance once per quantum
// - receive sampled at sample point, transmit loaded at bit start
// - zero processing time after sample point
// - resync may cut phase two below that
// - each resync shift limited to jump width
// - edge distance from sync is phase error
// - bit time spans four to twenty-five quanta; the fields here allow three to twenty-five
// - bit rates up to 1000 kbit/s
// - timing writes need init and change enable
module can_bit_timing
(
	input wire logic clk,
	input wire logic rstn,
	input can_bit_timing_pkg::axil_req_t axi_req,
	output can_bit_timing_pkg::axil_rsp_t axi_rsp,
	input wire logic can_rx,
	output logic can_tx,
	input wire logic tx_bit,
	input wire logic bus_idle,
	output logic rx_bit,
	output logic sample_point
);
	import can_bit_timing_pkg::*;

	bt_state_t st_r; // registered state
	bt_state_t st_nxt; // next state
	logic tick; // one quantum elapsed
	logic rx_lvl; // filtered bus level
	logic edge_fall; // recessive to dominant seen this quantum
	logic cfg_open; // timing registers writable
	logic [10:0] presc; // effective prescaler
	logic [4:0] base1; // prop plus phase one in quanta
	logic [4:0] base2; // phase two in quanta
	logic [4:0] sjwq; // jump width in quanta
	logic [4:0] l1; // working phase one limit
	logic [4:0] l2; // working phase two limit
	logic [4:0] perr; // phase error magnitude
	logic [4:0] jump; // applied shift
	logic [31:0] wr_word; // merged write data
	logic [31:0] old_word; // current value of the addressed register

	// extension bits above the six prescaler bits; the sum cannot overflow
	assign presc = {st_r.ext, st_r.cfg.quantum_prescaler} + `ONE_CLK;
	assign base1 = {1'b0, st_r.cfg.first_segment_field} + `ONE_TQ;
	assign base2 = {2'b0, st_r.cfg.second_segment_field} + `ONE_TQ;
	assign sjwq = {3'b0, st_r.cfg.jump_width} + `ONE_TQ;
	assign cfg_open = st_r.ctl_init && st_r.ctl_cce;
	assign edge_fall = st_r.last_rx && !rx_lvl;

	tq_prescaler tq_prescaler_i
	(
		.clk(clk),
		.rstn(rstn),
		.run(!st_r.ctl_init),
		.div(presc),
		.tick(tick)
	);

	rx_sync rx_sync_i
	(
		.clk(clk),
		.rstn(rstn),
		.pin(can_rx),
		.lvl(rx_lvl)
	);

	// register read view
	function automatic logic [31:0] reg_view(input bt_state_t s, input logic [11:0] a, input logic lv);
		logic [31:0] v;
		v = '0;
		unique case (a)
			`OFF_CTL:
			begin
				v[`CTL_INIT] = s.ctl_init;
				v[`CTL_CCE] = s.ctl_cce;
			end
			`OFF_BIT: v[`F_BIT] = s.cfg;
			`OFF_EXT: v[`F_EXT] = s.ext;
			`OFF_STAT: v[`F_STAT] = {s.seg, s.resynced, s.tx, lv, s.rx_bit};
			default: v = '0;
		endcase
		return v;
	endfunction

	// address is one of the mapped words
	function automatic logic mapped(input logic [11:0] a);
		return a == `OFF_CTL || a == `OFF_BIT || a == `OFF_EXT || a == `OFF_STAT;
	endfunction

	// byte lane merge of write data over the old word; unwritten lanes keep their value
	assign old_word = reg_view(st_r, st_r.awaddr, rx_lvl);
	for (genvar i = 0; i < 4; i++)
	begin : g_lane
		assign wr_word[i*8 +: 8] = st_r.wstrb[i] ? st_r.wdata[i*8 +: 8] : old_word[i*8 +: 8];
	end

	// bus slave and bit timing next state
	always_comb
	begin
		st_nxt = st_r;
		l1 = st_r.lim1;
		l2 = st_r.lim2;
		perr = '0;
		jump = '0;
		st_nxt.sample = 1'b0;

		// write address and data may arrive in either order
		if (axi_req.awvalid && st_r.rsp.awready)
		begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st_r.rsp.wready)
		begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = axi_req.wdata;
			st_nxt.wstrb = axi_req.wstrb;
		end
		// both halves held: commit and answer
		if (st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid)
		begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.rsp.bvalid = 1'b1;
			st_nxt.rsp.bresp = mapped(st_r.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (st_r.awaddr)
				`OFF_CTL:
				begin
					st_nxt.ctl_init = wr_word[`CTL_INIT];
					st_nxt.ctl_cce = wr_word[`CTL_CCE];
				end
				`OFF_BIT:
				begin
					// silently dropped unless configuration is open
					if (cfg_open)
						st_nxt.cfg = wr_word[`F_BIT];
				end
				`OFF_EXT:
				begin
					if (cfg_open)
						st_nxt.ext = wr_word[`F_EXT];
				end
				default:
				begin
					// status and unmapped words ignore writes
				end
			endcase
		end
		else if (st_r.rsp.bvalid && axi_req.bready)
		begin
			st_nxt.rsp.bvalid = 1'b0;
		end
		st_nxt.rsp.awready = !st_nxt.aw_got && !st_nxt.rsp.bvalid;
		st_nxt.rsp.wready = !st_nxt.w_got && !st_nxt.rsp.bvalid;

		// one read at a time, answered the next cycle
		if (axi_req.arvalid && st_r.rsp.arready)
		begin
			st_nxt.rsp.rvalid = 1'b1;
			st_nxt.rsp.rdata = reg_view(st_r, axi_req.araddr, rx_lvl);
			st_nxt.rsp.rresp = mapped(axi_req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (st_r.rsp.rvalid && axi_req.rready)
		begin
			st_nxt.rsp.rvalid = 1'b0;
		end
		st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

		// initialisation parks the bit engine and keeps the bus recessive
		if (st_r.ctl_init)
		begin
			st_nxt.seg = seg_sync;
			st_nxt.cnt = '0;
			st_nxt.tx = `RECESSIVE;
			st_nxt.resynced = 1'b0;
			st_nxt.last_rx = `RECESSIVE;
		end
		else if (tick)
		begin
			st_nxt.last_rx = rx_lvl;
			if (edge_fall && bus_idle)
			begin
				// the edge quantum becomes the sync segment
				st_nxt.seg = seg_first_segment_field;
				st_nxt.cnt = '0;
				st_nxt.lim1 = base1;
				st_nxt.resynced = 1'b1;
				st_nxt.tx = tx_bit;
			end
			else
			begin
				unique case (st_r.seg)
					seg_sync:
					begin
						// fixed single quantum, edges here carry no error
						st_nxt.seg = seg_first_segment_field;
						st_nxt.cnt = '0;
						st_nxt.lim1 = base1;
					end
					seg_first_segment_field:
					begin
						// late edge: stretch phase one by at most the jump width
						if (edge_fall && !st_r.resynced)
						begin
							perr = st_r.cnt + `ONE_TQ;
							jump = (perr > sjwq) ? sjwq : perr;
							l1 = st_r.lim1 + jump;
							st_nxt.resynced = 1'b1;
						end
						st_nxt.lim1 = l1;
						if (st_r.cnt + `ONE_TQ >= l1)
						begin
							// sample point between the phase segments
							st_nxt.seg = seg_second_segment_field;
							st_nxt.cnt = '0;
							st_nxt.lim2 = base2;
							st_nxt.sample = 1'b1;
							st_nxt.rx_bit = rx_lvl;
							st_nxt.resynced = 1'b0;
						end
						else
						begin
							st_nxt.cnt = st_r.cnt + `ONE_TQ;
						end
					end
					seg_second_segment_field:
					begin
						if (edge_fall && !st_r.resynced)
						begin
							// early edge: error is the quanta left in phase two
							perr = st_r.lim2 - st_r.cnt;
							st_nxt.resynced = 1'b1;
							if (perr <= sjwq)
							begin
								// whole remainder dropped, edge starts the next bit
								l2 = st_r.cnt;
							end
							else
							begin
								l2 = st_r.lim2 - sjwq;
							end
						end
						st_nxt.lim2 = l2;
						if (edge_fall && !st_r.resynced && perr <= sjwq)
						begin
							st_nxt.seg = seg_first_segment_field;
							st_nxt.cnt = '0;
							st_nxt.lim1 = base1;
							st_nxt.tx = tx_bit;
						end
						else if (st_r.cnt + `ONE_TQ >= l2)
						begin
							// next bit is already valid: no processing gap
							st_nxt.seg = seg_sync;
							st_nxt.cnt = '0;
							st_nxt.tx = tx_bit;
						end
						else
						begin
							st_nxt.cnt = st_r.cnt + `ONE_TQ;
						end
					end
				endcase
			end
		end
	end

	// state register with power-on values
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= '0;
			st_r.ctl_init <= `INIT_RST;
			st_r.ctl_cce <= `CCE_RST;
			st_r.cfg <= `BIT_RST;
			st_r.ext <= `EXT_RST;
			st_r.tx <= `RECESSIVE;
			st_r.last_rx <= `RECESSIVE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign axi_rsp = st_r.rsp;
	assign can_tx = st_r.tx;
	assign rx_bit = st_r.rx_bit;
	assign sample_point = st_r.sample;

	property p_sync_one;
		@(posedge clk) disable iff (!rstn)
		st_r.seg == seg_sync && tick && !st_r.ctl_init |=> st_r.seg == seg_first_segment_field && st_r.cnt == '0;
	endproperty
	a_sync_one: assert property (p_sync_one) else $error("sync segment not one quantum");

	property p_sample_place;
		@(posedge clk) disable iff (!rstn)
		sample_point |-> st_r.seg == seg_second_segment_field && st_r.cnt == '0 && rx_bit == $past(rx_lvl);
	endproperty
	a_sample_place: assert property (p_sample_place) else $error("sample not at phase boundary");

	property p_cfg_locked;
		@(posedge clk) disable iff (!rstn)
		!cfg_open |=> $stable(st_r.cfg) && $stable(st_r.ext);
	endproperty
	a_cfg_locked: assert property (p_cfg_locked) else $error("timing changed while locked");

	property p_per_quantum;
		@(posedge clk) disable iff (!rstn)
		!tick && !st_r.ctl_init |=> $stable(st_r.cnt) && $stable(st_r.seg);
	endproperty
	a_per_quantum: assert property (p_per_quantum) else $error("timing moved between quanta");

	property p_jump_bound;
		@(posedge clk) disable iff (!rstn)
		st_r.seg == seg_first_segment_field |-> st_r.lim1 <= base1 + sjwq && st_r.lim1 >= base1;
	endproperty
	a_jump_bound: assert property (p_jump_bound) else $error("phase one stretched past jump width");

	property p_second_phase_buffer_bound;
		@(posedge clk) disable iff (!rstn)
		st_r.seg == seg_second_segment_field |-> st_r.lim2 <= base2 && st_r.cnt < base2;
	endproperty
	a_second_phase_buffer_bound: assert property (p_second_phase_buffer_bound) else $error("phase two longer than programmed");

	property p_tx_at_bit_start;
		@(posedge clk) disable iff (!rstn)
		$changed(can_tx) && !$past(st_r.ctl_init) |-> $past(tick) && st_r.seg != seg_second_segment_field;
	endproperty
	a_tx_at_bit_start: assert property (p_tx_at_bit_start) else $error("transmit bit changed mid bit");

	property p_hard_sync;
		@(posedge clk) disable iff (!rstn)
		tick && edge_fall && bus_idle && !st_r.ctl_init |=> st_r.seg == seg_first_segment_field && st_r.cnt == '0 && st_r.resynced;
	endproperty
	a_hard_sync: assert property (p_hard_sync) else $error("idle edge did not restart bit");
endmodule

// ### rtl/rx_sync.sv
`timescale 1ns/1ns
`include "can_bit_timing_defines.svh"
// three-stage pin synchroniser with agreement filter
module rx_sync
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin,
	output logic lvl
);
	import can_bit_timing_pkg::*;
	sync_state_t st_r; // registered state
	sync_state_t st_nxt; // next state

	// only stages two and three are compared; stage one may be metastable
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ff = {st_r.ff[1:0], pin};
		if (st_r.ff[1] == st_r.ff[2])
			st_nxt.lvl = st_r.ff[2];
	end

	// state register, idle bus reads recessive
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st_r <= {`RX_IDLE, `RECESSIVE};
		else
			st_r <= st_nxt;
	end

	assign lvl = st_r.lvl;
endmodule

// ### rtl/tq_prescaler.sv
`timescale 1ns/1ns
`include "can_bit_timing_defines.svh"
// time quantum divider: one tick every div system clocks
module tq_prescaler
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [10:0] div,
	output logic tick
);
	import can_bit_timing_pkg::*;
	presc_state_t st_r; // registered state
	presc_state_t st_nxt; // next state

	// count system clocks; stopped counter restarts phase cleanly on run
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!run)
		begin
			st_nxt.cnt = '0;
		end
		else if (st_r.cnt >= div - `ONE_CLK)
		begin
			st_nxt.cnt = '0;
			st_nxt.tick = 1'b1;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + `ONE_CLK;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tick = st_r.tick;

	// the quantum ends exactly at the programmed clock count
	property p_tick_wrap;
		@(posedge clk) disable iff (!rstn)
		run && $stable(run) && st_r.cnt == div - `ONE_CLK |=> tick;
	endproperty
	a_tick_wrap: assert property (p_tick_wrap) else $error("quantum tick missing at wrap");
endmodule
